// ==== fpec_regs.svh ====
`ifndef FPEC_REGS_SVH
`define FPEC_REGS_SVH

// register byte offsets (array window selected by a high address bit)
`define FPEC_OFF_CTRL      16'h0000
`define FPEC_OFF_PROT      16'h0004
`define FPEC_OFF_STAT      16'h0008
`define FPEC_OFF_TARGET    16'h000C
`define FPEC_WIN_BIT       18

// control field positions
`define FPEC_CTRL_PGM      0
`define FPEC_CTRL_ERASE    1
`define FPEC_CTRL_MASS     2
`define FPEC_CTRL_HIGH_VOLTAGE_ENABLE     3
`define FPEC_CTRL_RESET    4'h0

// memory layout
`define FPEC_ARRAY_BASE    16'hC000
`define FPEC_PROT_ADDR     16'hFFBE
`define FPEC_LOW_PROT_LO   16'hBE00
`define FPEC_LOW_PROT_HI   16'hBFFF
`define FPEC_BPR_OPEN      8'hFF
`define FPEC_BPR_ALL       8'h00
`define FPEC_ERASED        8'hFF
`define FPEC_PAGE_BITS     6
`define FPEC_ROW_BITS      5

`endif

// ==== fpec_pkg.sv ====
`default_nettype none
package fpec_pkg;
   // ordered setup progress of one program or erase sequence
   typedef enum logic [2:0] {
      FPEC_IDLE,
      FPEC_SELECTED,
      FPEC_PROT_READ,
      FPEC_LATCHED,
      FPEC_HV_ON
   } fpec_seq_t;
endpackage
`default_nettype wire

// ==== fpec_ctrl.sv ====
`include "fpec_regs.svh"
`default_nettype none
module fpec_ctrl
   import fpec_pkg::*;
#(
   parameter int ARRAY_AW = 14
) (
   // clock and reset
   input  wire  logic        ref_clk,
   input  wire  logic        rst,
   // wishbone slave
   input  wire  logic        cyc_i,
   input  wire  logic        stb_i,
   input  wire  logic        we_i,
   input  wire  logic [18:0] adr_i,
   input  wire  logic [3:0]  sel_i,
   input  wire  logic [31:0] dat_i,
   output logic [31:0]       dat_o,
   output logic              ack_o,
   // analog side
   input  wire  logic        testHighVoltage,
   output logic              hvToArray,
   output logic              pumpOn,
   output logic              eraseWholeArray
);

   // -------------------------------------------------------------
   // storage and state
   // -------------------------------------------------------------
   logic [7:0]          mem [2**ARRAY_AW];  // nonvolatile bytes
   logic                programSelect;      // program select bit
   logic                eraseSelect;        // erase select bit
   logic                wholeArray;         // whole-array select
   logic                highVoltageEnable;  // pump enable bit
   fpec_seq_t           seq;                // setup progress
   logic [15:0]         target;             // latched target
   logic [15:0]         sweep;              // erase sweep address
   logic                sweepDone;          // erase completed
   logic [31:0]         rdata;              // read data register
   logic                ack;                // answer flag

   logic                next_programSelect;
   logic                next_eraseSelect;
   logic                next_wholeArray;
   logic                next_highVoltageEnable;
   fpec_seq_t           next_seq;
   logic [15:0]         next_target;
   logic [15:0]         next_sweep;
   logic                next_sweepDone;
   logic [31:0]         next_rdata;
   logic                next_ack;

   // array write port
   logic                memWe;
   logic [ARRAY_AW-1:0] memIdx;
   logic [7:0]          memData;

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   // map a 16-bit address onto the array index
   function automatic logic [ARRAY_AW-1:0] idx(input logic [15:0] a);
      logic [15:0] off;
      off = a - `FPEC_ARRAY_BASE;
      return off[ARRAY_AW-1:0];
   endfunction

   // true when the address sits inside the array
   function automatic logic inArray(input logic [15:0] a);
      return a >= `FPEC_ARRAY_BASE;
   endfunction

   // -------------------------------------------------------------
   // protection decode
   // -------------------------------------------------------------
   logic [7:0]  boundary;     // stored boundary byte
   logic [15:0] protStart;    // computed start of protection
   logic        targetProt;   // target lies in protected range
   logic        hvAllowed;    // setting high voltage permitted

   assign boundary = mem[idx(`FPEC_PROT_ADDR)];
   assign protStart = {2'b11, boundary, 6'b000000};

   always_comb begin
      targetProt = 1'b0;
      if (boundary == `FPEC_BPR_ALL) begin
         targetProt = 1'b1;
      end else if (boundary != `FPEC_BPR_OPEN) begin
         targetProt = (target >= protStart);
         if (target >= `FPEC_LOW_PROT_LO &&
             target <= `FPEC_LOW_PROT_HI) begin
            targetProt = 1'b1;
         end
         if (eraseSelect && wholeArray) begin
            targetProt = 1'b1;
         end
      end
      if (testHighVoltage) begin
         targetProt = 1'b0;
      end
      hvAllowed = (programSelect || eraseSelect) &&
                  (seq == FPEC_LATCHED) && !targetProt;
   end

   // -------------------------------------------------------------
   // bus decode
   // -------------------------------------------------------------
   logic        req;       // new request this cycle
   logic        winSel;    // array window selected
   logic [15:0] arrAddr;   // byte address in window
   logic [15:0] regOff;    // register offset

   assign req     = cyc_i && stb_i && !ack;
   assign winSel  = adr_i[`FPEC_WIN_BIT];
   assign arrAddr = adr_i[17:2];
   assign regOff  = {adr_i[15:2], 2'b00};

   // -------------------------------------------------------------
   // next-state logic
   // -------------------------------------------------------------
   always_comb begin
      logic       wPgm;
      logic       wErs;
      logic       wHv;
      logic [7:0] wb;
      logic [15:0] last;
      wPgm = 1'b0;
      wErs = 1'b0;
      wHv  = 1'b0;
      wb   = dat_i[7:0];
      last = 16'h0000;
      next_programSelect     = programSelect;
      next_eraseSelect       = eraseSelect;
      next_wholeArray        = wholeArray;
      next_highVoltageEnable = highVoltageEnable;
      next_seq               = seq;
      next_target            = target;
      next_sweep             = sweep;
      next_sweepDone         = sweepDone;
      next_rdata             = rdata;
      next_ack               = req;
      memWe                  = 1'b0;
      memIdx                 = idx(sweep);
      memData                = `FPEC_ERASED;

      // erase sweep while high voltage is on
      if (highVoltageEnable && eraseSelect && !sweepDone) begin
         if (wholeArray) begin
            last = 16'hFFFF;
         end else begin
            last = {target[15:6], 6'b111111};
         end
         memWe = 1'b1;
         if (sweep == last) begin
            next_sweepDone = 1'b1;
         end else begin
            next_sweep = sweep + 16'h0001;
         end
      end

      if (req && !winSel) begin
         // register access
         next_rdata = 32'h0000_0000;
         unique case (regOff)
            `FPEC_OFF_CTRL: begin
               next_rdata[`FPEC_CTRL_PGM]  = programSelect;
               next_rdata[`FPEC_CTRL_ERASE] = eraseSelect;
               next_rdata[`FPEC_CTRL_MASS] = wholeArray;
               next_rdata[`FPEC_CTRL_HIGH_VOLTAGE_ENABLE] = highVoltageEnable;
               if (we_i && sel_i[0]) begin
                  wPgm = wb[`FPEC_CTRL_PGM];
                  wErs = wb[`FPEC_CTRL_ERASE];
                  wHv  = wb[`FPEC_CTRL_HIGH_VOLTAGE_ENABLE];
                  if (wPgm && wErs) begin
                     wPgm = programSelect;
                     wErs = eraseSelect;
                  end
                  next_programSelect = wPgm;
                  next_eraseSelect   = wErs;
                  next_wholeArray    = wb[`FPEC_CTRL_MASS];
                  if (wHv && !highVoltageEnable) begin
                     if (hvAllowed) begin
                        next_highVoltageEnable = 1'b1;
                        next_seq   = FPEC_HV_ON;
                        next_sweepDone = 1'b0;
                        next_sweep = wholeArray ?
                           `FPEC_ARRAY_BASE :
                           {target[15:6], 6'b000000};
                     end
                  end else begin
                     next_highVoltageEnable = wHv;
                  end
                  if ((wPgm || wErs) && seq == FPEC_IDLE) begin
                     next_seq = FPEC_SELECTED;
                  end
                  if (!wPgm && !wErs && !next_highVoltageEnable) begin
                     next_seq = FPEC_IDLE;
                  end
               end
            end
            `FPEC_OFF_PROT: begin
               next_rdata[7:0] = boundary;
               if (!we_i && seq == FPEC_SELECTED) begin
                  next_seq = FPEC_PROT_READ;
               end
               // secured monitor dummy write
               if (we_i && seq == FPEC_PROT_READ) begin
                  next_target = `FPEC_PROT_ADDR;
                  next_seq    = FPEC_LATCHED;
               end
            end
            `FPEC_OFF_STAT: begin
               next_rdata[2:0] = seq;
               next_rdata[3]   = targetProt;
               next_rdata[4]   = sweepDone;
            end
            `FPEC_OFF_TARGET: begin
               next_rdata[15:0] = target;
            end
            default: begin
               next_rdata = 32'h0000_0000;
            end
         endcase
      end else if (req && winSel) begin
         // array window access
         next_rdata = 32'h0000_0000;
         if (inArray(arrAddr)) begin
            next_rdata[7:0] = mem[idx(arrAddr)];
         end
         if (!we_i && arrAddr == `FPEC_PROT_ADDR &&
             seq == FPEC_SELECTED) begin
            next_seq = FPEC_PROT_READ;
         end
         if (we_i && sel_i[0]) begin
            if (seq == FPEC_PROT_READ) begin
               next_target = arrAddr;
               next_seq    = FPEC_LATCHED;
            end else if (seq == FPEC_HV_ON && programSelect &&
                         inArray(arrAddr) &&
                         arrAddr[15:`FPEC_ROW_BITS] ==
                         target[15:`FPEC_ROW_BITS]) begin
               memWe   = 1'b1;
               memIdx  = idx(arrAddr);
               memData = mem[idx(arrAddr)] & wb;
            end
         end
      end
   end

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         programSelect     <= 1'b0;
         eraseSelect       <= 1'b0;
         wholeArray        <= 1'b0;
         highVoltageEnable <= 1'b0;
         seq               <= FPEC_IDLE;
         target            <= 16'h0000;
         sweep             <= 16'h0000;
         sweepDone         <= 1'b0;
         rdata             <= 32'h0000_0000;
         ack               <= 1'b0;
      end else begin
         programSelect     <= next_programSelect;
         eraseSelect       <= next_eraseSelect;
         wholeArray        <= next_wholeArray;
         highVoltageEnable <= next_highVoltageEnable;
         seq               <= next_seq;
         target            <= next_target;
         sweep             <= next_sweep;
         sweepDone         <= next_sweepDone;
         rdata             <= next_rdata;
         ack               <= next_ack;
      end
   end

   // array contents survive reset
   always_ff @(posedge ref_clk) begin
      if (memWe) begin
         mem[memIdx] <= memData;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   // pump follows high voltage bit
   assign hvToArray       = highVoltageEnable;
   assign pumpOn          = highVoltageEnable;
   assign eraseWholeArray = wholeArray;
   assign dat_o           = rdata;
   assign ack_o           = ack;

endmodule
`default_nettype wire

// ==== fpec_ctrl_chk.sv ====
`default_nettype none
module fpec_ctrl_chk
   import fpec_pkg::*;
#(
   parameter int ARRAY_AW = 14
) (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   // bus
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [18:0] adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // analog side
   input wire logic        testHighVoltage,
   input wire logic        hvToArray,
   input wire logic        pumpOn,
   input wire logic        eraseWholeArray
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // --------------------
   // bus handshake
   // --------------------
   ack_timely_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("no answer one cycle after a request");
   ack_once_a: assert property (ack_o |=> !ack_o)
      else $error("answer held longer than one cycle");
   ack_cause_a: assert property ($rose(ack_o) |->
      $past(cyc_i) && $past(stb_i))
      else $error("answer without a request");
   low_read_a: assert property (ack_o && !$past(we_i) && $past(adr_i[18])
      && $past(adr_i[17:16]) != 2'h3 |-> dat_o == 32'h0)
      else $error("array read below window not zero");
   // --------------------
   // high voltage and mode
   // --------------------
   hv_pump_a: assert property (hvToArray == pumpOn)
      else $error("pump and array voltage disagree");
   hv_cause_a: assert property (
      $rose(hvToArray) |-> $past(cyc_i) && $past(stb_i) && $past(we_i)
      && $past(adr_i) == 19'h0 && $past(dat_i[3]))
      else $error("high voltage rose without control write");
   hv_drop_a: assert property (
      $fell(hvToArray) |-> $past(stb_i) && $past(we_i)
      && !$past(dat_i[3]))
      else $error("high voltage fell without clearing write");
   whole_cause_a: assert property (
      $changed(eraseWholeArray) |-> $past(stb_i) && $past(we_i)
      && $past(adr_i) == 19'h0)
      else $error("whole array select moved without write");
   // main scenarios reached
   cover property ($rose(hvToArray));
   cover property (hvToArray && eraseWholeArray);
   cover property (ack_o && !$past(we_i));
endmodule

bind fpec_ctrl fpec_ctrl_chk #(.ARRAY_AW(ARRAY_AW)) u_chk (
   .ref_clk, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
   .dat_o, .ack_o, .testHighVoltage, .hvToArray, .pumpOn,
   .eraseWholeArray
);
`default_nettype wire

// ==== fpec_ctrl_tb.sv ====
`include "fpec_regs.svh"
`default_nettype none
module fpec_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // --------------------
   // signals
   // --------------------
   logic        ref_clk, rst, cyc_i, stb_i, we_i;
   logic [18:0] adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o;
   logic        ack_o, testHighVoltage, hvToArray, pumpOn;
   logic        eraseWholeArray;
   int          seed, checks, bad_count, i;
   logic [7:0]  r, dv [32];
   logic [15:0] a;
   localparam logic [18:0] CTRL = {3'h0, `FPEC_OFF_CTRL};
   localparam logic [18:0] PROT = {3'h0, `FPEC_OFF_PROT};
   localparam logic [18:0] STAT = {3'h0, `FPEC_OFF_STAT};
   localparam logic [18:0] TGT  = {3'h0, `FPEC_OFF_TARGET};

   fpec_ctrl #(.ARRAY_AW(14)) u_dut (
      .ref_clk, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .testHighVoltage, .hvToArray, .pumpOn,
      .eraseWholeArray
   );

   // 50 MHz clock
   initial begin
      ref_clk = 1'h0;
      forever #10 ref_clk = ~ref_clk;
   end

   // array byte address into the bus window
   function automatic logic [18:0] arr(input logic [15:0] x);
      return {1'h1, x, 2'h0};
   endfunction

   // expected protection of a target for a boundary byte
   function automatic logic prot(input logic [7:0] b, input logic [15:0] t);
      if (b == `FPEC_BPR_OPEN) return 1'h0;
      if (t >= `FPEC_LOW_PROT_LO && t <= `FPEC_LOW_PROT_HI) return 1'h1;
      return t >= {2'h3, b, 6'h00};
   endfunction

   task automatic chk(input string nm, input logic [7:0] got, exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one classic cycle, held until ack, read data left in r
   task automatic wb(input logic w, input logic [18:0] ad,
                     input logic [7:0] d);
      @(posedge ref_clk);
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      we_i  <= w;
      adr_i <= ad;
      sel_i <= 4'hF;
      dat_i <= {24'h000000, d};
      @(posedge ref_clk);
      // wait for the answer; only the watchdog ends a hang
      while (ack_o !== 1'h1) begin
         @(posedge ref_clk);
      end
      r = dat_o[7:0];
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
   endtask

   // select, read boundary, latch target, ask for high voltage
   task automatic start(input logic [7:0] m, input logic [15:0] t);
      wb(1'h1, CTRL, m);
      wb(1'h0, STAT, 8'h00);
      wb(1'h0, PROT, 8'h00);
      wb(1'h1, arr(t), 8'h00);
      wb(1'h1, CTRL, m | 8'h08);
   endtask

   task automatic hv(input logic e);
      @(posedge ref_clk);
      chk("hv", {7'h00, hvToArray}, {7'h00, e});
      chk("pump", {7'h00, pumpOn}, {7'h00, e});
   endtask

   // drop select, then high voltage
   task automatic finish;
      wb(1'h1, CTRL, 8'h08);
      wb(1'h1, CTRL, 8'h00);
   endtask

   // erase sweeps one byte a cycle, then done flag
   task automatic sweep(input int n);
      repeat (n) @(posedge ref_clk);
      wb(1'h0, STAT, 8'h00);
      chk("done", {7'h00, r[4]}, 8'h01);
   endtask

   task automatic stop_test;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // watchdog on a hang
   initial begin
      repeat (60000) @(posedge ref_clk);
      bad_count++;
      stop_test;
   end

   initial begin
      seed = 36;
      checks = 0;
      bad_count = 0;
      rst = 1'h1;
      {cyc_i, stb_i, we_i, testHighVoltage} = 4'h0;
      adr_i = 19'h0;
      sel_i = 4'hF;
      dat_i = 32'h0;
      repeat (12) @(posedge ref_clk);
      rst <= 1'h0;
      wb(1'h0, CTRL, 8'h00);
      chk("ctrl", r, 8'h00);
      wb(1'h1, CTRL, 8'h0A);
      hv(1'h0);
      wb(1'h1, CTRL, 8'h01);
      wb(1'h1, CTRL, 8'h03);
      wb(1'h0, CTRL, 8'h00);
      chk("sel", r, 8'h01);
      wb(1'h1, CTRL, 8'h00);
      // below the array window reads as zero
      wb(1'h0, arr(16'hBE00), 8'h00);
      chk("low", r, 8'h00);
      // page erase of boundary page under test voltage
      testHighVoltage <= 1'h1;
      start(8'h02, 16'hFF80);
      hv(1'h1);
      chk("whole", {7'h00, eraseWholeArray}, 8'h00);
      sweep(80);
      finish;
      testHighVoltage <= 1'h0;
      wb(1'h0, arr(`FPEC_PROT_ADDR), 8'h00);
      chk("page", r, `FPEC_ERASED);
      // whole array erase, boundary open
      start(8'h06, 16'hC000);
      hv(1'h1);
      chk("whole", {7'h00, eraseWholeArray}, 8'h01);
      sweep(16400);
      finish;
      wb(1'h0, arr(16'hFFC0), 8'h00);
      chk("trim", r, `FPEC_ERASED);
      // program a full row, then try one byte past it
      start(8'h01, 16'hC020);
      hv(1'h1);
      // each byte once, back to back
      for (i = 0; i < 32; i++) begin
         dv[i] = 8'($random(seed));
         wb(1'h1, arr(16'hC020 + 16'(i)), dv[i]);
      end
      wb(1'h1, arr(16'hC040), 8'h00);
      finish;
      for (i = 0; i < 32; i++) begin
         wb(1'h0, arr(16'hC020 + 16'(i)), 8'h00);
         chk("row", r, dv[i]);
      end
      wb(1'h0, arr(16'hC040), 8'h00);
      chk("past row", r, `FPEC_ERASED);
      // protect from FF80 upward
      start(8'h01, 16'hFFA0);
      wb(1'h1, arr(`FPEC_PROT_ADDR), 8'hFE);
      finish;
      wb(1'h0, PROT, 8'h00);
      chk("bound", r, 8'hFE);
      // mid-run reset keeps the array and boundary
      rst <= 1'h1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'h0;
      wb(1'h0, PROT, 8'h00);
      chk("kept", r, 8'hFE);
      start(8'h06, 16'hC000);
      hv(1'h0);
      wb(1'h1, CTRL, 8'h00);
      // dummy write to the boundary register latches
      wb(1'h1, CTRL, 8'h06);
      wb(1'h0, PROT, 8'h00);
      wb(1'h1, PROT, 8'h00);
      wb(1'h0, STAT, 8'h00);
      chk("latched", {5'h00, r[2:0]}, 8'h03);
      chk("refused", {7'h00, r[3]}, 8'h01);
      wb(1'h0, TGT, 8'h00);
      chk("target", r, 8'hBE);
      wb(1'h1, CTRL, 8'h0E);
      hv(1'h0);
      wb(1'h1, CTRL, 8'h00);
      // corner and random targets against the boundary
      for (i = 0; i < 14; i++) begin
         case (i)
            0: a = 16'hFF7F;
            1: a = 16'hFF80;
            2: a = 16'hBE00;
            3: a = 16'hBFFF;
            default: a = {2'h3, 14'($random(seed))};
         endcase
         start(8'h01, a);
         hv(!prot(8'hFE, a));
         wb(1'h1, CTRL, 8'h00);
      end
      stop_test;
   end
endmodule
`default_nettype wire
